// ### hdl/ioh_pkg.sv
package ioh_pkg;

	// -----------------------------------------------------------------
	// sizes and timing
	// -----------------------------------------------------------------
	localparam int HOSE_MAX = 4;
	localparam int DE_DELAY = 10;
	localparam logic [1:0] FLT_CYCLES = 2'h2;
	localparam logic [1:0] FLT_HOLD = 2'h3;
	localparam logic [4:0] ERR_IPL = 5'h11;
	localparam logic [3:0] CAP_RESET = 4'h1;

	// -----------------------------------------------------------------
	// up hose packet type codes
	// -----------------------------------------------------------------
	localparam logic [3:0] PT_CONT = 4'h0;
	localparam logic [3:0] PT_DMA_RD = 4'h1;
	localparam logic [3:0] PT_DMA_MWR = 4'h2;
	localparam logic [3:0] PT_DMA_UWR = 4'h3;
	localparam logic [3:0] PT_INTR = 4'h4;
	localparam logic [3:0] PT_WWS = 4'hc;
	localparam logic [3:0] PT_DENSE = 4'hd;
	localparam logic [3:0] PT_SPARSE = 4'he;

	// -----------------------------------------------------------------
	// packet lengths in hose cycles
	// -----------------------------------------------------------------
	localparam logic [4:0] CYC_WWS = 5'h01;
	localparam logic [4:0] CYC_SPARSE = 5'h03;
	localparam logic [4:0] CYC_DENSE = 5'h09;
	localparam logic [4:0] CYC_DMA_RD = 5'h02;
	localparam logic [4:0] CYC_INTR = 5'h02;
	localparam logic [4:0] CYC_OCTA = 5'h06;
	localparam logic [4:0] CYC_HEX = 5'h0a;
	localparam logic [4:0] CYC_DHEX = 5'h12;

	// -----------------------------------------------------------------
	// first-word fields
	// -----------------------------------------------------------------
	localparam int LEN_LSB = 8;
	localparam int CNT_LSB = 6;
	localparam logic [2:0] LEN_HEX = 3'h0;
	localparam logic [2:0] LEN_OCTA_MAX = 3'h3;
	localparam logic [2:0] LEN_DHEX = 3'h4;

	// -----------------------------------------------------------------
	// register offsets and bits
	// -----------------------------------------------------------------
	localparam logic [7:0] OFS_BUS_CFG = 8'h00;
	localparam logic [7:0] OFS_CTRL_ERR = 8'h04;
	localparam logic [7:0] OFS_DP_ERR = 8'h08;
	localparam logic [7:0] OFS_HOSE_ERR = 8'h0c;
	localparam logic [7:0] OFS_BUS_ERR = 8'h10;
	localparam logic [7:0] OFS_HOSE_CNT = 8'h14;
	localparam int B_CRD_DIS = 0;
	localparam int B_CWD_DIS = 1;
	localparam int B_INTR_EN = 0;
	localparam int B_SOFT_EN = 1;
	localparam int B_RBUF_IE = 4;
	localparam int B_CUP_VX = 5;
	localparam int B_DN_VX = 6;
	localparam int B_DUP_VX = 0;
	localparam int B_CRD = 0;
	localparam int B_CWD = 1;
	localparam int B_UDE = 2;
	localparam int B_FLT_SEEN = 3;
	localparam int B_DE_SEEN = 4;
	localparam int HE_PAR = 0;
	localparam int HE_PKT = 1;
	localparam int HE_OFLO = 2;
	localparam int HE_IE = 3;

	// -----------------------------------------------------------------
	// carriers and state
	// -----------------------------------------------------------------
	typedef struct packed {
		logic up_hose_word_valid;
		logic [3:0] up_packet_type_field;
		logic [31:0] data;
		logic par;
	} ioh_hose_word_t;

	typedef struct packed {
		logic active;
		logic [4:0] cnt;
		logic [4:0] exp;
		logic [3:0] cap;
		logic [3:0] fill;
		logic [3:0] err;
	} ioh_hose_t;

	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic crd_dis;
		logic cwd_dis;
		logic intr_en;
		logic soft_en;
		logic [3:0] int_err;
		logic crd;
		logic cwd;
		logic ude;
		logic flt_seen;
		logic de_seen;
		logic [DE_DELAY-1:0] de_pipe;
		logic [1:0] flt_cnt;
		logic [1:0] flt_hold;
		logic fsy1;
		logic fsy2;
		logic fsy3;
		logic dsy1;
		logic dsy2;
		logic armed;
		logic post;
		logic abort;
		ioh_hose_t [HOSE_MAX-1:0] hose;
	} ioh_state_t;

endpackage : ioh_pkg

// ### hdl/ioh_error_unit.sv
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps

module ioh_error_unit #(
	parameter int N_HOSE = ioh_pkg::HOSE_MAX
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// up hoses
	input wire ioh_pkg::ioh_hose_word_t [ioh_pkg::HOSE_MAX-1:0] up_hose_i,
	input wire logic [ioh_pkg::HOSE_MAX-1:0] rx_buf_full_i,
	input wire logic [ioh_pkg::HOSE_MAX-1:0] win_issue_i,
	// datapath events
	input wire logic first_data_cycle_i,
	input wire logic correctable_read_ecc_i,
	input wire logic correctable_write_ecc_i,
	input wire logic uncorrectable_ecc_i,
	input wire logic fatal_event_i,
	input wire logic [3:0] hard_int_err_i,
	// bus error lines
	input wire logic bus_fatal_line_i,
	output logic bus_fatal_line_o,
	output logic bus_fatal_line_oe_n_o,
	input wire logic bus_data_error_line_i,
	output logic bus_data_error_line_o,
	output logic bus_data_error_line_oe_n_o,
	// error interrupt and recovery
	output logic err_intr_post_o,
	output logic [4:0] err_intr_level_o,
	output logic bus_abort_o
);

	// -----------------------------------------------------------------
	// elaboration check
	// -----------------------------------------------------------------
	if (N_HOSE < 1 || N_HOSE > ioh_pkg::HOSE_MAX) begin : g_chk
		$error("N_HOSE out of range");
	end

	// -----------------------------------------------------------------
	// packet length lookup, zero means illegal
	// -----------------------------------------------------------------
	function automatic logic [4:0] pkt_cycles(input logic [3:0] typ,
		input logic [2:0] len);
		logic [4:0] r;
		r = 5'h00;
		unique case (typ)
			ioh_pkg::PT_WWS: r = ioh_pkg::CYC_WWS;
			ioh_pkg::PT_SPARSE: r = ioh_pkg::CYC_SPARSE;
			ioh_pkg::PT_DENSE: r = ioh_pkg::CYC_DENSE;
			ioh_pkg::PT_INTR: r = ioh_pkg::CYC_INTR;
			ioh_pkg::PT_DMA_RD, ioh_pkg::PT_DMA_MWR: begin
				if (len == ioh_pkg::LEN_HEX) begin
					r = (typ == ioh_pkg::PT_DMA_RD) ?
						ioh_pkg::CYC_DMA_RD : ioh_pkg::CYC_HEX;
				end else if (len <= ioh_pkg::LEN_OCTA_MAX) begin
					r = (typ == ioh_pkg::PT_DMA_RD) ?
						ioh_pkg::CYC_DMA_RD : ioh_pkg::CYC_OCTA;
				end else if (len == ioh_pkg::LEN_DHEX) begin
					r = (typ == ioh_pkg::PT_DMA_RD) ?
						ioh_pkg::CYC_DMA_RD : ioh_pkg::CYC_DHEX;
				end
			end
			ioh_pkg::PT_DMA_UWR: begin
				if (len == ioh_pkg::LEN_DHEX) begin
					r = ioh_pkg::CYC_DHEX;
				end
			end
			default: r = 5'h00;
		endcase
		return r;
	endfunction : pkt_cycles

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	ioh_pkg::ioh_state_t s_r;
	ioh_pkg::ioh_state_t s_nxt;

	always_ff @(posedge clk_i) begin
		s_r <= s_nxt;
	end

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb begin
		logic [31:0] wmask;
		logic wr;
		logic [31:0] clr_ctrl;
		logic [31:0] clr_dp;
		logic [31:0] clr_hose;
		logic [31:0] clr_bus;
		logic [31:0] rd;
		logic [3:0] hset;
		logic [4:0] explen;
		logic perr;
		logic dec;
		logic inc;
		logic flt_start;
		logic flt_other;
		logic src;
		logic de_start;
		ioh_pkg::ioh_hose_word_t w;
		wmask = '0;
		wr = 1'b0;
		clr_ctrl = '0;
		clr_dp = '0;
		clr_hose = '0;
		clr_bus = '0;
		rd = '0;
		hset = '0;
		explen = '0;
		perr = 1'b0;
		dec = 1'b0;
		inc = 1'b0;
		flt_start = 1'b0;
		flt_other = 1'b0;
		src = 1'b0;
		de_start = 1'b0;
		w = '0;
		s_nxt = s_r;

		// bus slave: ack one cycle after request, write at ack edge
		wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
			{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		s_nxt.ack = wb_cyc_i & wb_stb_i & ~s_r.ack;
		wr = s_r.ack & wb_cyc_i & wb_stb_i & wb_we_i;
		unique case (wb_adr_i)
			ioh_pkg::OFS_BUS_CFG: begin
				rd[ioh_pkg::B_CRD_DIS] = s_r.crd_dis;
				rd[ioh_pkg::B_CWD_DIS] = s_r.cwd_dis;
				if (wr) begin
					s_nxt.crd_dis = wmask[ioh_pkg::B_CRD_DIS] ?
						wb_dat_i[ioh_pkg::B_CRD_DIS] : s_r.crd_dis;
					s_nxt.cwd_dis = wmask[ioh_pkg::B_CWD_DIS] ?
						wb_dat_i[ioh_pkg::B_CWD_DIS] : s_r.cwd_dis;
				end
			end
			ioh_pkg::OFS_CTRL_ERR: begin
				rd[ioh_pkg::B_INTR_EN] = s_r.intr_en;
				rd[ioh_pkg::B_SOFT_EN] = s_r.soft_en;
				rd[ioh_pkg::B_RBUF_IE] = s_r.int_err[0];
				rd[ioh_pkg::B_CUP_VX] = s_r.int_err[1];
				rd[ioh_pkg::B_DN_VX] = s_r.int_err[2];
				if (wr) begin
					s_nxt.intr_en = wmask[ioh_pkg::B_INTR_EN] ?
						wb_dat_i[ioh_pkg::B_INTR_EN] : s_r.intr_en;
					s_nxt.soft_en = wmask[ioh_pkg::B_SOFT_EN] ?
						wb_dat_i[ioh_pkg::B_SOFT_EN] : s_r.soft_en;
					clr_ctrl = wb_dat_i & wmask;
				end
			end
			ioh_pkg::OFS_DP_ERR: begin
				rd[ioh_pkg::B_DUP_VX] = s_r.int_err[3];
				if (wr) begin
					clr_dp = wb_dat_i & wmask;
				end
			end
			ioh_pkg::OFS_HOSE_ERR: begin
				for (int h = 0; h < ioh_pkg::HOSE_MAX; h++) begin
					rd[4*h +: 4] = s_r.hose[h].err;
				end
				if (wr) begin
					clr_hose = wb_dat_i & wmask;
				end
			end
			ioh_pkg::OFS_BUS_ERR: begin
				rd[ioh_pkg::B_CRD] = s_r.crd;
				rd[ioh_pkg::B_CWD] = s_r.cwd;
				rd[ioh_pkg::B_UDE] = s_r.ude;
				rd[ioh_pkg::B_FLT_SEEN] = s_r.flt_seen;
				rd[ioh_pkg::B_DE_SEEN] = s_r.de_seen;
				if (wr) begin
					clr_bus = wb_dat_i & wmask;
				end
			end
			ioh_pkg::OFS_HOSE_CNT: begin
				for (int h = 0; h < ioh_pkg::HOSE_MAX; h++) begin
					rd[8*h +: 8] = {s_r.hose[h].fill, s_r.hose[h].cap};
				end
			end
			default: rd = '0;
		endcase
		s_nxt.rdat = s_nxt.ack ? rd : '0;

		// synchronisers for the bus error lines
		s_nxt.fsy1 = bus_fatal_line_i;
		s_nxt.fsy2 = s_r.fsy1;
		s_nxt.fsy3 = s_r.fsy2;
		s_nxt.dsy1 = bus_data_error_line_i;
		s_nxt.dsy2 = s_r.dsy1;

		// fault line: two cycles, never on top of another node
		flt_other = s_r.fsy2 & ~s_r.fsy3 & (s_r.flt_cnt == 2'h0) &
			(s_r.flt_hold == 2'h0);
		flt_start = fatal_event_i & (s_r.flt_cnt == 2'h0) &
			(s_r.flt_hold == 2'h0) & ~s_r.fsy2;
		if (flt_start) begin
			s_nxt.flt_cnt = ioh_pkg::FLT_CYCLES;
		end else if (s_r.flt_cnt != 2'h0) begin
			s_nxt.flt_cnt = 2'(s_r.flt_cnt - 2'h1);
			if (s_r.flt_cnt == 2'h1) begin
				s_nxt.flt_hold = ioh_pkg::FLT_HOLD;
			end
		end else if (s_r.flt_hold != 2'h0) begin
			s_nxt.flt_hold = 2'(s_r.flt_hold - 2'h1);
		end
		s_nxt.abort = flt_start | flt_other;
		s_nxt.flt_seen = (s_r.flt_seen & ~clr_bus[ioh_pkg::B_FLT_SEEN]) |
			flt_other;

		// data error line: one cycle, tenth after first data cycle
		s_nxt.crd = (s_r.crd & ~clr_bus[ioh_pkg::B_CRD]) |
			(first_data_cycle_i & correctable_read_ecc_i);
		s_nxt.cwd = (s_r.cwd & ~clr_bus[ioh_pkg::B_CWD]) |
			(first_data_cycle_i & correctable_write_ecc_i);
		s_nxt.ude = (s_r.ude & ~clr_bus[ioh_pkg::B_UDE]) |
			(first_data_cycle_i & uncorrectable_ecc_i);
		de_start = first_data_cycle_i & (uncorrectable_ecc_i |
			(correctable_read_ecc_i & ~s_r.crd_dis) |
			(correctable_write_ecc_i & ~s_r.cwd_dis));
		s_nxt.de_pipe = {s_r.de_pipe[ioh_pkg::DE_DELAY-2:0],
			de_start};
		s_nxt.de_seen = (s_r.de_seen & ~clr_bus[ioh_pkg::B_DE_SEEN]) |
			s_r.dsy2;

		// hard internal errors
		s_nxt.int_err[0] = (s_r.int_err[0] & ~clr_ctrl[ioh_pkg::B_RBUF_IE]) |
			hard_int_err_i[0];
		s_nxt.int_err[1] = (s_r.int_err[1] & ~clr_ctrl[ioh_pkg::B_CUP_VX]) |
			hard_int_err_i[1];
		s_nxt.int_err[2] = (s_r.int_err[2] & ~clr_ctrl[ioh_pkg::B_DN_VX]) |
			hard_int_err_i[2];
		s_nxt.int_err[3] = (s_r.int_err[3] & ~clr_dp[ioh_pkg::B_DUP_VX]) |
			hard_int_err_i[3];

		// up hose checking
		for (int h = 0; h < ioh_pkg::HOSE_MAX; h++) begin
			hset = '0;
			dec = 1'b0;
			inc = 1'b0;
			w = up_hose_i[h];
			explen = pkt_cycles(w.up_packet_type_field,
				w.data[ioh_pkg::LEN_LSB +: 3]);
			perr = w.up_hose_word_valid & ~(^{w.data,
				w.up_packet_type_field, w.par});
			if (h < N_HOSE) begin
				if (perr) begin
					hset[ioh_pkg::HE_PAR] = 1'b1;
					s_nxt.hose[h].active = 1'b0;
				end else if (w.up_hose_word_valid &&
					w.up_packet_type_field != ioh_pkg::PT_CONT) begin
					if (s_r.hose[h].active) begin
						hset[ioh_pkg::HE_PKT] = 1'b1;
					end
					if (explen == 5'h00) begin
						hset[ioh_pkg::HE_PKT] = 1'b1;
						s_nxt.hose[h].active = 1'b0;
					end else if (rx_buf_full_i[h]) begin
						hset[ioh_pkg::HE_OFLO] = 1'b1;
						s_nxt.hose[h].active = 1'b0;
					end else begin
						s_nxt.hose[h].active = (explen != 5'h01);
						s_nxt.hose[h].cnt = 5'h01;
						s_nxt.hose[h].exp = explen;
						dec = (w.up_packet_type_field == ioh_pkg::PT_WWS) ||
							(w.up_packet_type_field == ioh_pkg::PT_DENSE) ||
							(w.up_packet_type_field == ioh_pkg::PT_SPARSE);
						// error flag and commander id bits are not read
						if (w.up_packet_type_field == ioh_pkg::PT_WWS) begin
							s_nxt.hose[h].cap =
								w.data[ioh_pkg::CNT_LSB +: 4];
						end
					end
				end else if (w.up_hose_word_valid) begin
					if (!s_r.hose[h].active) begin
						hset[ioh_pkg::HE_PKT] = 1'b1;
					end else if (s_r.hose[h].exp == 5'h00) begin
						hset[ioh_pkg::HE_IE] = 1'b1;
						s_nxt.hose[h].active = 1'b0;
					end else begin
						s_nxt.hose[h].cnt = 5'(s_r.hose[h].cnt + 5'h01);
						s_nxt.hose[h].active =
							(5'(s_r.hose[h].cnt + 5'h01) != s_r.hose[h].exp);
					end
				end else if (s_r.hose[h].active) begin
					hset[ioh_pkg::HE_PKT] = 1'b1;
					s_nxt.hose[h].active = 1'b0;
				end

				// filled window buffer count
				inc = win_issue_i[h];
				if (inc && !dec && s_r.hose[h].fill >= s_r.hose[h].cap) begin
					hset[ioh_pkg::HE_IE] = 1'b1;
				end else if (dec && !inc && s_r.hose[h].fill == 4'h0) begin
					hset[ioh_pkg::HE_IE] = 1'b1;
				end else if (inc && !dec) begin
					s_nxt.hose[h].fill = 4'(s_r.hose[h].fill + 4'h1);
				end else if (dec && !inc) begin
					s_nxt.hose[h].fill = 4'(s_r.hose[h].fill - 4'h1);
				end
			end
			s_nxt.hose[h].err = (s_r.hose[h].err & ~clr_hose[4*h +: 4]) |
				hset;
			if (s_r.abort) begin
				// outstanding work and fill counts are lost, error bits and capacities are kept
				s_nxt.hose[h].active = 1'b0;
				s_nxt.hose[h].fill = 4'h0;
			end
		end

		// level 17 error interrupt, once until all sources clear
		src = (|s_r.int_err) | s_r.ude |
			(s_r.crd & s_r.soft_en & ~s_r.crd_dis) |
			(s_r.cwd & s_r.soft_en & ~s_r.cwd_dis);
		for (int h = 0; h < ioh_pkg::HOSE_MAX; h++) begin
			src = src | (|s_r.hose[h].err);
		end
		s_nxt.post = s_r.intr_en & s_r.armed & src;
		if (s_nxt.post) begin
			s_nxt.armed = 1'b0;
		end else if (!src) begin
			s_nxt.armed = 1'b1;
		end

		// synchronous node reset
		if (rst_i) begin
			s_nxt = '0;
			s_nxt.armed = 1'b1;
			for (int h = 0; h < ioh_pkg::HOSE_MAX; h++) begin
				s_nxt.hose[h].cap = ioh_pkg::CAP_RESET;
			end
		end
	end

	// -----------------------------------------------------------------
	// outputs
	// -----------------------------------------------------------------
	assign wb_ack_o = s_r.ack;
	assign wb_dat_o = s_r.rdat;
	assign bus_fatal_line_o = (s_r.flt_cnt != 2'h0);
	assign bus_fatal_line_oe_n_o = (s_r.flt_cnt == 2'h0);
	assign bus_data_error_line_o = s_r.de_pipe[ioh_pkg::DE_DELAY-1];
	assign bus_data_error_line_oe_n_o = ~s_r.de_pipe[ioh_pkg::DE_DELAY-1];
	assign err_intr_post_o = s_r.post;
	assign err_intr_level_o = ioh_pkg::ERR_IPL;
	assign bus_abort_o = s_r.abort;

endmodule : ioh_error_unit

// ### tb/ioh_error_unit_chk.sv
`timescale 1ns/1ps
module ioh_error_unit_chk #(
	parameter int N_HOSE = 4
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// watched ports
	input wire logic first_data_cycle_i,
	input wire logic uncorrectable_ecc_i,
	input wire logic fatal_event_i,
	input wire logic bus_fatal_line_o,
	input wire logic bus_fatal_line_oe_n_o,
	input wire logic bus_data_error_line_o,
	input wire logic bus_data_error_line_oe_n_o,
	input wire logic err_intr_post_o,
	input wire logic [4:0] err_intr_level_o,
	input wire logic bus_abort_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_de_hard;
		first_data_cycle_i && uncorrectable_ecc_i |-> ##10 bus_data_error_line_o;
	endproperty
	a_de_hard: assert property (p_de_hard)
		else $error("hard data error not driven");
	property p_de_cause;
		bus_data_error_line_o |-> $past(first_data_cycle_i, 10);
	endproperty
	a_de_cause: assert property (p_de_cause)
		else $error("data error line off its cycle");
	property p_de_oe;
		bus_data_error_line_oe_n_o == !bus_data_error_line_o;
	endproperty
	a_de_oe: assert property (p_de_oe)
		else $error("data error enable mismatch");
	property p_flt_two;
		$rose(bus_fatal_line_o) |=> bus_fatal_line_o ##1 !bus_fatal_line_o;
	endproperty
	a_flt_two: assert property (p_flt_two)
		else $error("fault line not two cycles");
	property p_flt_cause;
		$rose(bus_fatal_line_o) |-> $past(fatal_event_i);
	endproperty
	a_flt_cause: assert property (p_flt_cause)
		else $error("fault line without cause");
	property p_flt_abort;
		$rose(bus_fatal_line_o) |-> bus_abort_o;
	endproperty
	a_flt_abort: assert property (p_flt_abort)
		else $error("fault without abort");
	property p_flt_oe;
		bus_fatal_line_oe_n_o != bus_fatal_line_o;
	endproperty
	a_flt_oe: assert property (p_flt_oe)
		else $error("fault enable mismatch");
	property p_level;
		err_intr_level_o == ioh_pkg::ERR_IPL;
	endproperty
	a_level: assert property (p_level)
		else $error("wrong interrupt level");
	property p_post_one;
		err_intr_post_o |=> !err_intr_post_o [*2];
	endproperty
	a_post_one: assert property (p_post_one)
		else $error("repeated interrupt post");
	c_flt: cover property ($rose(bus_fatal_line_o));
	c_de: cover property (bus_data_error_line_o);
	c_post: cover property (err_intr_post_o);
endmodule : ioh_error_unit_chk

// ### tb/ioh_hose_model.sv
`timescale 1ns/1ps
module ioh_hose_model (
	// clock and request
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [3:0] typ_i,
	input wire logic [4:0] ncyc_i,
	input wire logic [31:0] w0_i,
	input wire logic bad_par_i,
	// hose word
	output ioh_pkg::ioh_hose_word_t word_o,
	output logic busy_o
);
	logic [4:0] left_r = 5'h00;
	initial word_o = '0;
	assign busy_o = left_r != 5'h00;
	// odd parity over data, type and parity bit
	always @(posedge clk_i) begin
		if (go_i) begin
			left_r <= ncyc_i - 5'h01;
			word_o.up_hose_word_valid <= 1'b1;
			word_o.up_packet_type_field <= typ_i;
			word_o.data <= w0_i;
			word_o.par <= ~^{w0_i, typ_i} ^ bad_par_i;
		end else if (busy_o) begin
			left_r <= left_r - 5'h01;
			word_o.up_packet_type_field <= 4'h0;
			word_o.data <= ~word_o.data;
			word_o.par <= ~^{~word_o.data, 4'h0} ^ bad_par_i;
		end else begin
			word_o.up_hose_word_valid <= 1'b0;
			word_o.data <= ~word_o.data;
		end
	end
endmodule : ioh_hose_model

// ### tb/ioh_error_unit_tb.sv
`timescale 1ns/1ps
bind ioh_error_unit ioh_error_unit_chk #(.N_HOSE(N_HOSE)) chk (.*);
module ioh_error_unit_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, we = 1'b0, go = 1'b0, bad = 1'b0, busy, ack;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = '0, w0 = '0, rdat, rd;
	ioh_pkg::ioh_hose_word_t [3:0] hose;
	ioh_pkg::ioh_hose_word_t word;
	logic [3:0] typ = '0, full = '0, issue = '0, hard = '0, cnt;
	logic [4:0] ncyc = 5'h01, lvl;
	logic [1:0] hsel = '0;
	logic fdc = 0, crd = 0, cwd = 0, ude = 0, fev = 0, xflt = 0, xde = 0;
	logic flt_o, flt_oe_n, de_o, de_oe_n, post, abort, drv, ipost;
	int fails = 0, total_checks = 0, ncl = 0, posts = 0, des = 0, flts = 0;
	int aborts = 0, p0, d0;
	logic [1:0] hs [6] = '{1, 2, 3, 0, 1, 2};
	logic [3:0] ty [6] = '{4'h4, 4'h5, 4'h2, 4'h1, 4'hc, 4'hc};
	logic [4:0] nc [6] = '{5'h02, 5'h01, 5'h06, 5'h01, 5'h01, 5'h01};
	int eb [6] = '{4, 9, 13, 1, 6, 11};
	always #12.5 clk_i = ~clk_i;
	always_comb begin
		for (int h = 0; h < 4; h++) begin
			hose[h] = word;
			hose[h].up_hose_word_valid = word.up_hose_word_valid && hsel == h;
		end
	end
	ioh_hose_model adapter (.clk_i(clk_i), .go_i(go), .typ_i(typ),
		.ncyc_i(ncyc), .w0_i(w0), .bad_par_i(bad), .word_o(word),
		.busy_o(busy));
	ioh_error_unit uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .up_hose_i(hose),
		.rx_buf_full_i(full), .win_issue_i(issue), .first_data_cycle_i(fdc),
		.correctable_read_ecc_i(crd), .correctable_write_ecc_i(cwd),
		.uncorrectable_ecc_i(ude), .fatal_event_i(fev),
		.hard_int_err_i(hard), .bus_fatal_line_i(~flt_oe_n | xflt),
		.bus_fatal_line_o(flt_o), .bus_fatal_line_oe_n_o(flt_oe_n),
		.bus_data_error_line_i(~de_oe_n | xde), .bus_data_error_line_o(de_o),
		.bus_data_error_line_oe_n_o(de_oe_n), .err_intr_post_o(post),
		.err_intr_level_o(lvl), .bus_abort_o(abort));
	always @(posedge clk_i) begin
		ncl++;
		posts += (post === 1'b1);
		des += (de_o === 1'b1);
		flts += (flt_o === 1'b1);
		aborts += (abort === 1'b1);
		if (ncl == 20000) begin
			fails++;
			summarize();
		end
	end
	task automatic summarize;
		if (fails == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize
	// data error line expected unless its disable bit is set
	function automatic logic exp_drv(input logic [2:0] m, input int k);
		return k == 2 || !m[k];
	endfunction : exp_drv
	// corrected errors interrupt only with soft enable, no disable
	function automatic logic exp_post(input logic [2:0] m, input int k);
		return k == 2 || (m[2] && !m[k]);
	endfunction : exp_post
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		chk(rd, e);
	endtask : rchk
	task automatic send(input logic [1:0] h, input logic [3:0] t,
		input logic [4:0] n, input logic [31:0] d, input logic b);
		@(posedge clk_i);
		hsel <= h;
		typ <= t;
		ncyc <= n;
		w0 <= d;
		bad <= b;
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		@(posedge clk_i);
		while (busy === 1'b1) @(posedge clk_i);
		repeat (4) @(posedge clk_i);
	endtask : send
	initial begin
		void'($urandom(83));
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		rchk(8'h14, 32'h0101_0101);
		rchk(8'h40, 32'h0000_0000);
		cnt = 4'($urandom_range(15, 2));
		@(posedge clk_i);
		issue <= 4'h1;
		@(posedge clk_i);
		issue <= 4'h0;
		send(2'h0, 4'hc, 5'h01, {2'b01, 4'($urandom), 16'h0, cnt, 6'h0}, 0);
		rchk(8'h14, {24'h0101_01, 4'h0, cnt});
		rchk(8'h0c, 32'h0000_0000);
		chk(32'(posts), 32'h0000_0000);
		wb(1'b1, 8'h04, 32'h0000_0001);
		for (int i = 0; i < 6; i++) begin
			full <= (i == 4) ? 4'h2 : 4'h0;
			p0 = posts;
			send(hs[i], ty[i], nc[i], {21'h0, (i == 2) ? 3'h5 : 3'h0,
				8'($urandom)}, i == 0);
			rchk(8'h0c, 32'h0000_0001 << eb[i]);
			chk(32'(posts - p0), 32'h0000_0001);
			wb(1'b1, 8'h0c, 32'hffff_ffff);
		end
		full <= 4'h0;
		for (int i = 0; i < 8; i++) begin
			wb(1'b1, 8'h00, 32'(i[1:0]));
			wb(1'b1, 8'h04, {30'h0, i[2], 1'b1});
			for (int k = 0; k < 3; k++) begin
				drv = exp_drv(3'(i), k);
				ipost = exp_post(3'(i), k);
				p0 = posts;
				d0 = des;
				@(posedge clk_i);
				fdc <= 1'b1;
				{ude, cwd, crd} <= 3'b001 << k;
				@(posedge clk_i);
				fdc <= 1'b0;
				{ude, cwd, crd} <= 3'b000;
				repeat (14) @(posedge clk_i);
				chk(32'(des - d0), 32'(drv));
				chk(32'(posts - p0), 32'(ipost));
				rchk(8'h10, (32'h1 << k) | (32'(drv) << 4));
				wb(1'b1, 8'h10, 32'h0000_001f);
			end
		end
		for (int k = 0; k < 4; k++) begin
			p0 = posts;
			@(posedge clk_i);
			hard <= 4'h1 << k;
			@(posedge clk_i);
			hard <= 4'h0;
			if (k < 3)
				rchk(8'h04, (32'h0000_0010 << k) | 32'h0000_0003);
			else
				rchk(8'h08, 32'h0000_0001);
			chk(32'(posts - p0), 32'h0000_0001);
			wb(1'b1, (k < 3) ? 8'h04 : 8'h08, (k < 3) ? 32'h73 : 32'h1);
		end
		@(posedge clk_i);
		fev <= 1'b1;
		@(posedge clk_i);
		fev <= 1'b0;
		repeat (8) @(posedge clk_i);
		chk(32'(flts), 32'h0000_0002);
		rchk(8'h00, 32'h0000_0003);
		rchk(8'h04, 32'h0000_0003);
		xflt <= 1'b1;
		repeat (2) @(posedge clk_i);
		fev <= 1'b1;
		xflt <= 1'b0;
		@(posedge clk_i);
		fev <= 1'b0;
		repeat (8) @(posedge clk_i);
		chk(32'(flts), 32'h0000_0002);
		chk(32'(aborts), 32'h0000_0002);
		wb(1'b0, 8'h10, 32'h0000_0000);
		chk(rd & 32'h0000_0008, 32'h0000_0008);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rchk(8'h14, 32'h0101_0101);
		rchk(8'h04, 32'h0000_0000);
		summarize();
	end
endmodule : ioh_error_unit_tb
